/* File: src/serial_channel_pkg.sv */
// Constants, field layouts and mode decoding shared by the serial channel design.
// Assumes a single 100 MHz clock domain and a plain strobe-based register port.
package serial_channel_pkg;

  // Register offsets; transmit buffer word sits at AA alone, AB is unmapped
  localparam logic [7:0] ADDR_TX_HOLD  = 8'hAA;
  localparam logic [7:0] ADDR_CTRL2    = 8'hAD;
  localparam logic [7:0] ADDR_RX_HOLD  = 8'hAE;
  localparam logic [7:0] ADDR_MODE     = 8'hB0;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hB1;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hB2;

  // Second control register fields
  localparam int CTL_TX_ON    = 0;
  localparam int CTL_TX_VAC   = 1;
  localparam int CTL_RX_ON    = 2;
  localparam int CTL_RX_FULL  = 3;
  localparam int CTL_IRQ_SEL  = 4;
  localparam int CTL_B2B      = 5;
  localparam int CTL_INV      = 6;
  localparam int CTL_ERR_EN   = 7;
  localparam logic [7:0] CTRL2_RESET = 8'h02;
  localparam logic [7:0] CTRL2_WMASK = 8'hF5;

  // Serial mode word fields
  localparam int MODE_STPS  = 4;
  localparam int MODE_PRY   = 5;
  localparam int MODE_PRYE  = 6;
  localparam int MODE_IOPOL = 7;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [2:0] SMD_OFF  = 3'h0;
  localparam logic [2:0] SMD_SYNC = 3'h1;
  localparam logic [2:0] SMD_I2C  = 3'h2;
  localparam logic [2:0] SMD_A7   = 3'h4;
  localparam logic [2:0] SMD_A8   = 3'h5;
  localparam logic [2:0] SMD_A9   = 3'h6;

  // Receive buffer upper fields
  localparam int RXB_OVR = 12;
  localparam int RXB_FRM = 13;
  localparam int RXB_PAR = 14;
  localparam int RXB_SUM = 15;

  // Interrupt status and mask layout
  localparam int IRQ_TX  = 0;
  localparam int IRQ_RX  = 1;
  localparam int IRQ_ERR = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // Default clocks per bit; the baud generator lives elsewhere
  localparam int BIT_CYCLES_DEF = 16;

  // Inversion is honoured only in these modes
  function automatic logic invert_allowed(input logic [2:0] smd);
    return (smd == SMD_SYNC) || (smd == SMD_A7) || (smd == SMD_A8);
  endfunction

  function automatic logic [3:0] frame_len(input logic [2:0] smd);
    return (smd == SMD_A7) ? 4'h7 : ((smd == SMD_A9) ? 4'h9 : 4'h8);
  endfunction

  function automatic logic [8:0] data_mask(input logic [2:0] smd);
    return (smd == SMD_A7) ? 9'h07F : ((smd == SMD_A9) ? 9'h1FF : 9'h0FF);
  endfunction

endpackage

/* File: src/tx_frame_if.sv */
// Signals between the register side and the transmit shift engine.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface tx_frame_if;
  logic       start;
  logic [8:0] bits;
  logic [3:0] nbits;
  logic       par_en;
  logic       par_val;
  logic       two_stop;
  logic       shift_empty;
  logic       txd;
  modport ctl (output start, bits, nbits, par_en, par_val, two_stop, input shift_empty, txd);
  modport eng (input start, bits, nbits, par_en, par_val, two_stop, output shift_empty, txd);
endinterface

/* File: src/tx_shift_engine.sv */
// Transmit shift engine: start bit, data LSB first, optional parity, one or two stops.
// Assumes start is raised only while shift_empty is high.
`timescale 1ns/100ps
module tx_shift_engine
  import serial_channel_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF
)(
  input  wire logic  sys_clk_i,
  input  wire logic  srst_i,
  tx_frame_if.eng    tx
);
  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} tx_state_e;
  typedef struct packed {
    tx_state_e  st;
    logic [15:0] cnt;
    logic [8:0]  sh;
    logic [3:0]  left;
    logic        par_en;
    logic        par_val;
    logic        stop2;
    logic        line;
  } eng_s;
  localparam eng_s ENG_RESET = '{T_IDLE, 16'h0, 9'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1};
  localparam logic [15:0] LAST = 16'(BIT_CYCLES - 1);
  eng_s s_r;
  eng_s s_nxt;

  // Bit sequencer; every bit lasts BIT_CYCLES clocks
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.cnt = s_r.cnt + 16'h1;
    if (s_r.st == T_IDLE)
    begin
      s_nxt.cnt = 16'h0;
      s_nxt.line = 1'b1;
      if (tx.start)
      begin
        s_nxt = '{T_START, 16'h0, tx.bits, tx.nbits, tx.par_en, tx.par_val, tx.two_stop, 1'b0};
      end
    end
    else if (s_r.cnt == LAST)
    begin
      s_nxt.cnt = 16'h0;
      unique case (s_r.st)
        T_START:
        begin
          // Count is left whole here so that DATA runs once per data bit
          s_nxt.st = T_DATA;
          s_nxt.line = s_r.sh[0];
        end
        T_DATA:
        begin
          s_nxt.sh = s_r.sh >> 1;
          s_nxt.left = s_r.left - 4'h1;
          s_nxt.line = s_r.sh[1];
          if (s_r.left == 4'h0)
          begin
            s_nxt.st = s_r.par_en ? T_PAR : T_STOP;
            s_nxt.line = s_r.par_en ? s_r.par_val : 1'b1;
          end
        end
        T_PAR:
        begin
          s_nxt.st = T_STOP;
          s_nxt.line = 1'b1;
        end
        T_STOP:
        begin
          s_nxt.stop2 = 1'b0;
          if (!s_r.stop2)
          begin
            s_nxt.st = T_IDLE;
          end
        end
        default:
        begin
          s_nxt.st = T_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      s_r <= ENG_RESET;
    else
      s_r <= s_nxt;
  end

  // Empty only between frames, so the completion event follows the last stop bit
  assign tx.shift_empty = (s_r.st == T_IDLE);
  assign tx.txd = s_r.line;
endmodule

/* File: src/serial_channel_txrx_control.sv */
// Serial channel top: register port, transmit buffer, receiver, error flags and interrupt.
// Assumes a synchronous strobe master on sys_clk_i and an asynchronous receive pin.
`timescale 1ns/100ps
module serial_channel_txrx_control
  import serial_channel_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF
)(
  input  wire logic        sys_clk_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             err_sig_o,
  output logic             irq_o
);
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} rx_state_e;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  mode;
    logic [8:0]  tx_hold;
    logic [8:0]  tx_last;
    logic [8:0]  rx_buf;
    logic        ovr;
    logic        frm;
    logic        par;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic [15:0] rdata;
    logic        irq;
    logic        err_sig;
    logic        txd;
    logic        meta;
    logic        sync;
    logic        prev_empty;
    rx_state_e   rx_st;
    logic [15:0] rx_cnt;
    logic [3:0]  rx_idx;
    logic [8:0]  rx_sh;
    logic        rx_perr;
  } top_s;
  localparam top_s TOP_RESET = '{CTRL2_RESET, MODE_RESET, 9'h0, 9'h0, 9'h0, 1'b0, 1'b0, 1'b0,
                                 3'h0, IRQ_MASK_RESET, 16'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1,
                                 1'b1, R_IDLE, 16'h0, 4'h0, 9'h0, 1'b0};
  localparam logic [15:0] LAST = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF = 16'(BIT_CYCLES / 2 - 1);

  top_s s_r;
  top_s s_nxt;
  tx_frame_if tx ();

  logic [2:0] smd;
  logic       inv_eff;
  logic       async_mode;
  logic       rx_enabled;
  logic       rx_lvl;
  logic       tx_go;
  logic       frame_done;
  logic [8:0] rx_data;
  logic       rd_rxb;
  logic       wr_txb;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded modes and bus strobes
  assign smd        = s_r.mode[2:0];
  assign inv_eff    = s_r.ctrl[CTL_INV] && invert_allowed(smd);
  assign async_mode = (smd == SMD_A7) || (smd == SMD_A8) || (smd == SMD_A9);
  assign rx_enabled = s_r.ctrl[CTL_RX_ON] && (smd != SMD_OFF);
  assign rx_lvl     = s_r.sync ^ s_r.mode[MODE_IOPOL];
  assign rd_rxb     = rd_i && (addr_i == ADDR_RX_HOLD);
  assign wr_txb     = wr_i && (addr_i == ADDR_TX_HOLD);

  // Hand the held word to the shifter only when allowed and the shifter is idle
  assign tx_go = s_r.ctrl[CTL_TX_ON] && (smd != SMD_OFF) && !s_r.ctrl[CTL_TX_VAC]
                 && tx.shift_empty;

  // Frame fields for the shift engine; data bits above the frame length stay zero
  assign tx.start    = tx_go;
  assign tx.bits     = (s_r.tx_hold ^ {9{inv_eff}}) & data_mask(smd);
  assign tx.nbits    = frame_len(smd) - 4'h1;
  assign tx.par_en   = async_mode && s_r.mode[MODE_PRYE];
  assign tx.par_val  = (^tx.bits) ^ ~s_r.mode[MODE_PRY];
  assign tx.two_stop = s_r.mode[MODE_STPS];

  tx_shift_engine #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_tx (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .tx        (tx.eng)
  );

  // A frame is complete at the middle of its first stop bit
  assign frame_done = (s_r.rx_st == R_STOP) && (s_r.rx_cnt == LAST) && rx_enabled;
  assign rx_data    = inv_eff ? (s_r.rx_sh ^ data_mask(smd)) : s_r.rx_sh;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state: bus clears first, hardware sets after so that a coinciding event wins; a buffer write still beats a hand-over
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.meta = rxd_i;
    s_nxt.sync = s_r.meta;
    s_nxt.txd = tx.txd ^ s_r.mode[MODE_IOPOL];
    s_nxt.prev_empty = tx.shift_empty;
    // Read data stands for one cycle only, so it defaults to zero
    s_nxt.rdata = 16'h0;

    // Reads: data valid in the next cycle only, unmapped offsets answer zero
    if (rd_i)
    begin
      unique case (addr_i)
        ADDR_CTRL2:    s_nxt.rdata = {8'h00, s_r.ctrl};
        ADDR_MODE:     s_nxt.rdata = {8'h00, s_r.mode};
        ADDR_IRQ_STAT: s_nxt.rdata = {13'h0, s_r.irq_stat};
        ADDR_IRQ_MASK: s_nxt.rdata = {13'h0, s_r.irq_mask};
        ADDR_RX_HOLD:  s_nxt.rdata = {s_r.ovr | s_r.frm | s_r.par, s_r.par, s_r.frm, s_r.ovr,
                                      3'h0, s_r.rx_buf};
        default:       s_nxt.rdata = 16'h0;
      endcase
    end
    // Reading the status register clears it; events further down still win
    if (rd_i && (addr_i == ADDR_IRQ_STAT))
    begin
      s_nxt.irq_stat = 3'h0;
    end
    // Reading the buffer drops receive-complete and the per-frame error flags
    if (rd_rxb)
    begin
      s_nxt.ctrl[CTL_RX_FULL] = 1'b0;
      s_nxt.frm = 1'b0;
      s_nxt.par = 1'b0;
    end

    // Writes; the two flag bits of the control register are not writable
    if (wr_i)
    begin
      unique case (addr_i)
        ADDR_CTRL2:    s_nxt.ctrl = (wdata_i[7:0] & CTRL2_WMASK) | (s_r.ctrl & ~CTRL2_WMASK);
        ADDR_MODE:     s_nxt.mode = wdata_i[7:0];
        ADDR_IRQ_MASK: s_nxt.irq_mask = wdata_i[2:0];
        default:       s_nxt.mode = s_r.mode;
      endcase
    end

    // Transmit buffer: hand-over sets vacant, a write refills it
    if (tx_go)
    begin
      s_nxt.ctrl[CTL_TX_VAC] = 1'b1;
      s_nxt.tx_last = s_r.tx_hold;
    end
    // Continuous receive in synchronous mode: reading the buffer re-arms a dummy send
    if (rd_rxb && s_r.ctrl[CTL_B2B] && (smd == SMD_SYNC) && s_r.ctrl[CTL_TX_VAC])
    begin
      s_nxt.tx_hold = s_r.tx_last;
      s_nxt.ctrl[CTL_TX_VAC] = 1'b0;
    end
    if (wr_txb)
    begin
      s_nxt.tx_hold = wdata_i[8:0];
      s_nxt.ctrl[CTL_TX_VAC] = 1'b0;
    end

    // Transmit interrupt cause: buffer hand-over or end of the last stop bit
    if (s_r.ctrl[CTL_IRQ_SEL] ? (tx.shift_empty && !s_r.prev_empty) : tx_go)
    begin
      s_nxt.irq_stat[IRQ_TX] = 1'b1;
    end

    // Receiver; samples mid-bit after a half-bit start check
    s_nxt.rx_cnt = s_r.rx_cnt + 16'h1;
    unique case (s_r.rx_st)
      R_IDLE:
      begin
        s_nxt.rx_cnt = 16'h0;
        if (rx_enabled && !rx_lvl)
        begin
          s_nxt.rx_st = R_START;
        end
      end
      R_START:
      begin
        if (s_r.rx_cnt == HALF)
        begin
          s_nxt.rx_cnt = 16'h0;
          s_nxt.rx_idx = 4'h0;
          s_nxt.rx_sh = 9'h0;
          s_nxt.rx_st = rx_lvl ? R_IDLE : R_DATA;
        end
      end
      R_DATA:
      begin
        if (s_r.rx_cnt == LAST)
        begin
          s_nxt.rx_cnt = 16'h0;
          s_nxt.rx_sh[s_r.rx_idx] = rx_lvl;
          s_nxt.rx_idx = s_r.rx_idx + 4'h1;
          if (s_r.rx_idx == frame_len(smd) - 4'h1)
          begin
            s_nxt.rx_st = tx.par_en ? R_PAR : R_STOP;
            s_nxt.rx_perr = 1'b0;
          end
        end
      end
      R_PAR:
      begin
        if (s_r.rx_cnt == LAST)
        begin
          s_nxt.rx_cnt = 16'h0;
          s_nxt.rx_perr = rx_lvl != ((^s_r.rx_sh) ^ ~s_r.mode[MODE_PRY]);
          s_nxt.rx_st = R_STOP;
        end
      end
      R_STOP:
      begin
        if (s_r.rx_cnt == LAST)
        begin
          s_nxt.rx_st = R_IDLE;
        end
      end
    endcase

    // Delivery; a full buffer keeps its old word and flags the overrun instead
    if (frame_done)
    begin
      s_nxt.irq_stat[IRQ_RX] = 1'b1;
      if (s_r.ctrl[CTL_RX_FULL] && !rd_rxb)
      begin
        s_nxt.ovr = 1'b1;
        s_nxt.irq_stat[IRQ_ERR] = 1'b1;
      end
      else
      begin
        s_nxt.rx_buf = rx_data;
        s_nxt.ctrl[CTL_RX_FULL] = 1'b1;
        s_nxt.frm = async_mode && !rx_lvl;
        s_nxt.par = async_mode && s_r.rx_perr;
        if (async_mode && (!rx_lvl || s_r.rx_perr))
        begin
          s_nxt.irq_stat[IRQ_ERR] = 1'b1;
        end
      end
    end

    // Channel off or reception off: receiver idles and error flags drop
    if (!rx_enabled)
    begin
      s_nxt.rx_st = R_IDLE;
      s_nxt.ovr = 1'b0;
      s_nxt.frm = 1'b0;
      s_nxt.par = 1'b0;
    end

    // Error pin registered from current flags and obeys its enable; interrupt registered from next-state flags
    s_nxt.err_sig = s_r.ctrl[CTL_ERR_EN] && (s_r.ovr || s_r.frm || s_r.par);
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; reset leaves transfers disabled and the buffer vacant
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      s_r <= TOP_RESET;
    else
      s_r <= s_nxt;
  end

  // Outputs straight from flip-flops
  assign rdata_o   = s_r.rdata;
  assign txd_o     = s_r.txd;
  assign err_sig_o = s_r.err_sig;
  assign irq_o     = s_r.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  AST_TX_GATED: assert property (tx.start |-> s_r.ctrl[CTL_TX_ON] && !s_r.ctrl[CTL_TX_VAC])
    else $error("transmit started while disabled or with empty buffer");
  AST_VAC_FILL: assert property (wr_txb |=> !s_r.ctrl[CTL_TX_VAC] && (s_r.tx_hold == $past(wdata_i[8:0])))
    else $error("buffer write did not clear vacant flag");
  AST_VAC_SET: assert property (tx_go && !wr_txb && !rd_rxb |=> s_r.ctrl[CTL_TX_VAC])
    else $error("hand-over did not set vacant flag");
  AST_RX_GATED: assert property ($rose(s_r.ctrl[CTL_RX_FULL]) |-> $past(s_r.ctrl[CTL_RX_ON]))
    else $error("frame accepted while reception disabled");
  AST_RX_READ_CLR: assert property (rd_rxb && !frame_done |=> !s_r.ctrl[CTL_RX_FULL])
    else $error("reading receive buffer did not clear complete flag");
  AST_IRQ_SEL: assert property (tx_go && !s_r.ctrl[CTL_IRQ_SEL] |=> s_r.irq_stat[IRQ_TX])
    else $error("buffer empty did not raise transmit interrupt");
  AST_SHIFT_BUSY: assert property (tx.start |=> !tx.shift_empty [*3])
    else $error("shift empty high during a frame");
  AST_INV_GATE: assert property (tx.start && !invert_allowed(smd) |->
                                 tx.bits == (s_r.tx_hold & data_mask(smd)))
    else $error("inversion applied in a mode that forbids it");
  AST_ERR_OFF: assert property (!s_r.ctrl[CTL_ERR_EN] |=> !err_sig_o)
    else $error("error signal driven while disabled");
  AST_ERR_CLEAR: assert property (!rx_enabled |=> !s_r.ovr && !s_r.frm && !s_r.par)
    else $error("error flags kept while reception off");
  AST_RESET: assert property ($past(srst_i) |-> s_r.ctrl == CTRL2_RESET)
    else $error("control register reset value wrong");

  // Transmit side
  AST_TX_MODE_OFF: assert property ((smd == SMD_OFF) |-> !tx.start)
    else $error("transmit started with the channel off");
  AST_INV_ON: assert property (tx.start && inv_eff |-> tx.bits == (~s_r.tx_hold & data_mask(smd)))
    else $error("inversion not applied to frame bits");
  AST_LINE_IDLE: assert property (tx.shift_empty |-> tx.txd)
    else $error("line not idle high between frames");
  AST_IRQ_COMPLETE: assert property (s_r.ctrl[CTL_IRQ_SEL] && tx.shift_empty && !s_r.prev_empty
                                     |=> s_r.irq_stat[IRQ_TX])
    else $error("transmission completed did not raise transmit interrupt");
  AST_B2B_RELOAD: assert property (rd_rxb && s_r.ctrl[CTL_B2B] && (smd == SMD_SYNC) && s_r.ctrl[CTL_TX_VAC]
                                   |=> !s_r.ctrl[CTL_TX_VAC])
    else $error("continuous receive read did not re-arm a transmit");
  AST_VAC_HOLD: assert property (!tx_go && !wr_txb && !rd_rxb |=> $stable(s_r.ctrl[CTL_TX_VAC]))
    else $error("buffer-vacant flag changed without an event");

  // Receive side
  AST_RX_OFF_IDLE: assert property (!rx_enabled |=> s_r.rx_st == R_IDLE)
    else $error("receiver active while reception off");
  AST_FULL_SET: assert property (frame_done |=> s_r.ctrl[CTL_RX_FULL])
    else $error("completed frame did not set receive-complete");
  AST_FULL_HOLD: assert property (!frame_done && !rd_rxb |=> $stable(s_r.ctrl[CTL_RX_FULL]))
    else $error("receive-complete flag changed without an event");
  AST_FULL_KEEP: assert property (frame_done && s_r.ctrl[CTL_RX_FULL] && !rd_rxb |=> $stable(s_r.rx_buf))
    else $error("held receive word overwritten");
  AST_ERR_ON: assert property (s_r.ctrl[CTL_ERR_EN] && s_r.ovr |=> err_sig_o)
    else $error("error signal not driven while enabled");

  // Scenario coverage
  COV_FRAME_RX: cover property (frame_done && !s_r.ctrl[CTL_RX_FULL]);
  COV_TX_DONE: cover property (tx.shift_empty && !s_r.prev_empty);
  COV_OVERRUN: cover property (frame_done && s_r.ctrl[CTL_RX_FULL] && !rd_rxb);
  COV_IRQ: cover property ($rose(irq_o));
  COV_B2B: cover property (rd_rxb && s_r.ctrl[CTL_B2B] && s_r.ctrl[CTL_TX_VAC]);
endmodule

/* File: test/serial_line_peer.sv */
// Far end of the serial line: sends frames into the channel and captures its frames.
// Assumes 8N1 framing, idle high, and the same bit length in clocks as the channel.
`timescale 1ns/100ps
module serial_line_peer
#(
  parameter int BIT_CYCLES = 4
)(
  input  wire logic sys_clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  logic [7:0] got;
  int         count;

  initial
  begin
    line_o = 1'b1;
    got    = 8'h00;
    count  = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Send one frame: start, eight data bits LSB first, one stop, then idle high
  task automatic send(input logic [7:0] d);
    int i;
    for (i = 0; i < 10; i++)
    begin
      @(posedge sys_clk_i);
      line_o <= (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : d[i-1]);
      repeat (BIT_CYCLES - 1) @(posedge sys_clk_i);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Capture frames; sampling at mid bit tolerates the channel's output register lag
  always
  begin : capture
    logic [7:0] r;
    int         k;
    @(negedge line_i);
    repeat (BIT_CYCLES / 2) @(posedge sys_clk_i);
    for (k = 0; k < 8; k++)
    begin
      repeat (BIT_CYCLES) @(posedge sys_clk_i);
      r[k] = line_i;
    end
    repeat (BIT_CYCLES) @(posedge sys_clk_i);
    got   = r;
    count = count + 1;
  end
endmodule

/* File: test/serial_channel_txrx_control_tb_top.sv */
// Self-checking bench for the serial channel: register port tasks plus a line peer.
// Assumes the register map of the shared package and a short bit length.
`timescale 1ns/100ps
module serial_channel_txrx_control_tb_top
  import serial_channel_pkg::*;
;
  localparam int BC = 4;

  logic        sys_clk_i = 1'b0;
  logic        srst_i    = 1'b1;
  logic [7:0]  addr      = 8'h00;
  logic [15:0] wdata     = 16'h0000;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [15:0] rdata;
  logic        txd;
  logic        rxd;
  logic        err_sig;
  logic        irq;
  int          num_errors  = 0;
  int          check_count = 0;
  logic [15:0] v;
  logic [2:0]  modes [3] = '{3'h1, 3'h5, 3'h3};
  logic [7:0]  inv_exp [3] = '{8'hF0, 8'hF0, 8'h0F};

  always #5 sys_clk_i = ~sys_clk_i;

  serial_channel_txrx_control #(.BIT_CYCLES(BC)) dut (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .addr_i    (addr),
    .wdata_i   (wdata),
    .wr_i      (wr),
    .rd_i      (rd),
    .rdata_o   (rdata),
    .rxd_i     (rxd),
    .txd_o     (txd),
    .err_sig_o (err_sig),
    .irq_o     (irq)
  );

  serial_line_peer #(.BIT_CYCLES(BC)) peer (
    .sys_clk_i (sys_clk_i),
    .line_i    (txd),
    .line_o    (rxd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reporting and the single end of the run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Register port: one-cycle strobes, read data taken in the cycle after the strobe
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge sys_clk_i);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    rd   <= 1'b1;
    addr <= a;
    @(posedge sys_clk_i);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd_reg(a, d);
    chk(name, e, d);
  endtask

  // Optionally load the holding buffer, then wait, bounded, for the peer to capture a frame
  task automatic tx_frame(input logic load, input logic [8:0] d, input logic [7:0] e);
    int c0;
    int n;
    c0 = peer.count;
    if (load)
      wr_reg(ADDR_TX_HOLD, {7'h00, d});
    for (n = 0; n < 400 && peer.count == c0; n++)
      @(posedge sys_clk_i);
    if (peer.count == c0)
    begin
      num_errors++;
      $display("BAD tx frame expected capture seen none");
      wrap_up();
    end
    else
      chk("tx frame", {8'h00, e}, {8'h00, peer.got});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
    // Reset values and an unmapped read
    rdchk("ctrl reset", ADDR_CTRL2, 16'h0002);
    rdchk("mask reset", ADDR_IRQ_MASK, 16'h0000);
    rdchk("status reset", ADDR_IRQ_STAT, 16'h0000);
    rdchk("unmapped", 8'hAB, 16'h0000);
    chk("idle lines", 16'h0004, {13'h0, txd, err_sig, irq});
    // Status flags ignore writes
    wr_reg(ADDR_CTRL2, 16'h00FF);
    rdchk("ctrl flags ro", ADDR_CTRL2, 16'h00F7);
    wr_reg(ADDR_CTRL2, 16'h0000);
    $display("test reset and access done");

    // Held word waits while transmit is off
    wr_reg(ADDR_MODE, {13'h0, SMD_A8});
    wr_reg(ADDR_IRQ_MASK, 16'h0001);
    wr_reg(ADDR_TX_HOLD, 16'h005A);
    rdchk("ctrl held", ADDR_CTRL2, 16'h0000);
    repeat (60) @(posedge sys_clk_i);
    chk("no frame while off", 16'h0000, peer.count[15:0]);
    chk("irq quiet", 16'h0000, {15'h0, irq});
    v = 16'h0000;
    wr_reg(ADDR_CTRL2, 16'h0001);
    tx_frame(1'b0, 9'h000, 8'h5A);
    rdchk("ctrl vacant", ADDR_CTRL2, 16'h0003);
    chk("irq buffer empty", 16'h0001, {15'h0, irq});
    rdchk("status tx", ADDR_IRQ_STAT, 16'h0001);
    chk("irq cleared", 16'h0000, {15'h0, irq});
    // Interrupt on transmission completed
    wr_reg(ADDR_CTRL2, 16'h0011);
    wr_reg(ADDR_TX_HOLD, 16'h00C3);
    rdchk("status busy", ADDR_IRQ_STAT, 16'h0000);
    for (int n = 0; n < 400 && irq !== 1'b1; n++)
      @(posedge sys_clk_i);
    if (irq !== 1'b1)
    begin
      num_errors++;
      $display("BAD tx done irq expected 1 seen %b", irq);
      wrap_up();
    end
    chk("tx capture", 16'h00C3, {8'h00, peer.got});
    rdchk("status done", ADDR_IRQ_STAT, 16'h0001);
    $display("test transmit done");

    // Inversion acts only in the listed modes
    for (int m = 0; m < 3; m++)
    begin
      wr_reg(ADDR_MODE, {13'h0, modes[m]});
      wr_reg(ADDR_CTRL2, 16'h0041);
      tx_frame(1'b1, 9'h00F, inv_exp[m]);
    end
    wr_reg(ADDR_CTRL2, 16'h0000);
    $display("test inversion done");

    // Reception gated by the enable bit, then a good frame
    wr_reg(ADDR_MODE, {13'h0, SMD_A8});
    peer.send(8'h3C);
    repeat (8) @(posedge sys_clk_i);
    rdchk("rx off", ADDR_CTRL2, 16'h0002);
    wr_reg(ADDR_CTRL2, 16'h0004);
    peer.send(8'hA5);
    repeat (8) @(posedge sys_clk_i);
    rdchk("rx full", ADDR_CTRL2, 16'h000E);
    rdchk("rx data", ADDR_RX_HOLD, 16'h00A5);
    rdchk("rx read clears", ADDR_CTRL2, 16'h0006);
    $display("test receive done");

    // Overrun, error output and flag clearing on receive disable
    peer.send(8'h11);
    peer.send(8'h22);
    repeat (8) @(posedge sys_clk_i);
    chk("err out off", 16'h0000, {15'h0, err_sig});
    wr_reg(ADDR_CTRL2, 16'h0084);
    repeat (3) @(posedge sys_clk_i);
    chk("err out on", 16'h0001, {15'h0, err_sig});
    rdchk("rx overrun", ADDR_RX_HOLD, 16'h9011);
    wr_reg(ADDR_CTRL2, 16'h0080);
    repeat (3) @(posedge sys_clk_i);
    rd_reg(ADDR_RX_HOLD, v);
    chk("rx flags off", 16'h0000, v & 16'hF000);
    chk("err out cleared", 16'h0000, {15'h0, err_sig});
    $display("test errors done");

    // Continuous receive in synchronous mode: a buffer read re-sends the last word
    wr_reg(ADDR_MODE, {13'h0, SMD_SYNC});
    wr_reg(ADDR_CTRL2, 16'h0021);
    rd_reg(ADDR_RX_HOLD, v);
    tx_frame(1'b0, 9'h000, 8'h0F);
    $display("test continuous receive done");
    wrap_up();
  end
endmodule
